// [shared/agc_adc_cal_regs.svh]
// Register offsets, field positions and reset values of the bank.
// Assumes a 10-bit byte address on the configuration memory port.
`ifndef AGC_ADC_CAL_REGS_SVH
`define AGC_ADC_CAL_REGS_SVH

`define OFS_BB_OSC_READBACK 10'h345
`define OFS_BB_OSC_OVERRIDE 10'h346
`define OFS_RC_OSC_HIGH 10'h34F
`define OFS_RC_OSC_LOW 10'h350
`define OFS_ADC_CFG_LOW 10'h359
`define OFS_ADC_CFG_HIGH 10'h35A
`define OFS_OOK_RATES 10'h35B
`define OFS_LOOP_CFG 10'h35C
`define OFS_LOOP_MODE 10'h35D

`define RST_BB_OSC_OVERRIDE 7'h00
`define RST_ADC_CFG_LOW 4'h0
`define RST_ADC_CFG_HIGH 7'h1F
`define RST_OOK_RATES 6'h11
`define RST_LOOP_CFG 8'h9C
`define RST_LOOP_MODE 7'h00

`define BIT_OVERRIDE_EN 0
`define BIT_REF_POWER 4
`define BIT_EXTRA_LOW 1
`define BIT_NO_MAX 0

`define GAIN_FRONT_MAX 2'h2
`define GAIN_FILTER_MAX 2'h2
`define GAIN_RESERVED 2'h3
`define FILTER_SHIFT 2

`endif

// [shared/agc_adc_cal_pkg.sv]
// Types shared by the gain-loop register bank and its calibration helper.
// Assumes the offsets header is included by the design files.
package agc_adc_cal_pkg;

  typedef struct packed {
    logic write;
    logic read;
    logic [9:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic extraLow;
    logic [1:0] front;
    logic mixer;
    logic [1:0] filter;
  } gain_t;

  typedef enum logic [1:0] {
    LOOP_FREE,
    LOOP_MANUAL,
    LOOP_HOLD,
    LOOP_LOCK
  } loop_op_t;

  typedef enum logic [1:0] {
    FILT_NONE,
    FILT_ON_READ,
    FILT_ON_TICK,
    FILT_ALL
  } filt_mode_t;

  typedef enum {
    LOCK_TRACK,
    LOCK_FROZEN
  } lock_state_t;

  typedef enum {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } cal_state_t;

endpackage : agc_adc_cal_pkg

// [hw/bb_osc_cal_seq.sv]
// Baseband filter calibration sequencer and oscillator word override.
// Assumes the analog measurement returns a one-cycle valid with its word.
`include "agc_adc_cal_regs.svh"
module bb_osc_cal_seq
  import agc_adc_cal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic calEnable,
  input wire logic measValid,
  input wire logic [5:0] measWord,
  input wire logic [6:0] overrideReg,
  output logic calRun,
  output logic calDone,
  output logic [5:0] calWord,
  output logic [5:0] activeWord
);
  cal_state_t state;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= CAL_IDLE;
    end else if (!calEnable) begin
      state <= CAL_IDLE;
    end else begin
      case (state)
        CAL_IDLE: state <= CAL_RUN;
        CAL_RUN: if (measValid) state <= CAL_DONE;
        CAL_DONE: state <= CAL_DONE;
        default: state <= CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calWord <= 6'h00;
    end else if (state == CAL_RUN && measValid) begin
      calWord <= measWord;
    end
  end

  assign calRun = (state == CAL_RUN);
  assign calDone = (state == CAL_DONE);
  assign activeWord = overrideReg[`BIT_OVERRIDE_EN] ?
    overrideReg[6:1] : calWord;

endmodule : bb_osc_cal_seq

// [hw/agc_adc_cal_ctrl.sv]
// Gain loop, auxiliary ADC and calibration result register bank.
// Assumes the configuration memory port and all inputs share clk_sys.
`include "agc_adc_cal_regs.svh"

module agc_adc_cal_ctrl
  import agc_adc_cal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mem_req_t memReq,
  output logic [7:0] memRdata,
  input wire logic bbFilterCalEnable,
  output logic bbFilterCalDone,
  output logic bbFilterCalRun,
  input wire logic bbOscMeasValid,
  input wire logic [5:0] bbOscMeasWord,
  output logic [5:0] bbOscActiveWord,
  input wire logic rcOscCalValid,
  input wire logic [15:0] rcOscCalWord,
  output logic [1:0] auxAdcRefSelect,
  output logic [1:0] auxAdcChannelSelect,
  output logic auxAdcRefPower,
  input wire logic adcSampleValid,
  input wire logic [7:0] adcSample,
  output logic [7:0] loopSample,
  output logic [7:0] adcReadback,
  input wire logic ookMode,
  input wire logic ookTracking,
  input wire logic manchesterTick,
  input wire logic fskLoopTick,
  output logic loopTick,
  input wire logic gainRaise,
  input wire logic gainLower,
  input wire logic preambleFound,
  output gain_t gain
);

  logic [6:0] bbOscOverride;
  logic [15:0] rcOscResult;
  logic [3:0] adcCfgLow;
  logic [6:0] adcCfgHigh;
  logic [5:0] ookRates;
  logic [7:0] loopCfg;
  logic [6:0] loopMode;
  logic [5:0] bbOscCalWord;
  logic [7:0] filtAcc;
  logic [7:0] rateCount;
  logic [7:0] rateLimit;
  logic [2:0] rateExp;
  logic modeWrite;
  filt_mode_t filtMode;
  loop_op_t loopOp;
  lock_state_t lockState;
  gain_t next_gain;
  gain_t manualGain;

  // Match on the address of one register
  function automatic logic hit(input mem_req_t r, input logic [9:0] a);
    hit = (r.addr == a);
  endfunction : hit

  // Divider end count for an exponent: 2^(e+1) symbols minus one
  function automatic logic [7:0] expLimit(input logic [2:0] e);
    expLimit = 8'hFF >> (3'h7 - e);
  endfunction : expLimit

  // One step of the gain loop, lowest change order moves first
  function automatic gain_t stepGain(
    input gain_t g,
    input logic up,
    input logic [7:0] cfg
  );
    gain_t n;
    logic moved;
    gain_t top;
    n = g;
    moved = 1'b0;
    top = '{1'b0, `GAIN_FRONT_MAX, 1'b1, `GAIN_FILTER_MAX};
    if (up && g.extraLow) begin
      n.extraLow = 1'b0;
      moved = 1'b1;
    end
    for (int p = 0; p < 4; p++) begin
      if (!moved && cfg[7:6] == 2'(p)) begin
        if (up && g.front < `GAIN_FRONT_MAX) begin
          n.front = g.front + 2'h1;
          moved = 1'b1;
        end else if (!up && g.front != 2'h0) begin
          n.front = g.front - 2'h1;
          moved = 1'b1;
        end
      end
      if (!moved && cfg[5:4] == 2'(p)) begin
        if (up != g.mixer) begin
          n.mixer = up;
          moved = 1'b1;
        end
      end
      if (!moved && cfg[3:2] == 2'(p)) begin
        if (up && g.filter < `GAIN_FILTER_MAX) begin
          n.filter = g.filter + 2'h1;
          moved = 1'b1;
        end else if (!up && g.filter != 2'h0) begin
          n.filter = g.filter - 2'h1;
          moved = 1'b1;
        end
      end
    end
    if (!moved && !up && cfg[`BIT_EXTRA_LOW] && g.front == 2'h0) begin
      n.extraLow = 1'b1;
    end
    if (cfg[`BIT_NO_MAX] && n == top) begin
      n = g;
    end
    stepGain = n;
  endfunction : stepGain

  // Configuration registers written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bbOscOverride <= `RST_BB_OSC_OVERRIDE;
      adcCfgLow <= `RST_ADC_CFG_LOW;
      adcCfgHigh <= `RST_ADC_CFG_HIGH;
      ookRates <= `RST_OOK_RATES;
      loopCfg <= `RST_LOOP_CFG;
      loopMode <= `RST_LOOP_MODE;
    end else if (memReq.write) begin
      if (hit(memReq, `OFS_BB_OSC_OVERRIDE)) begin
        bbOscOverride <= memReq.wdata[6:0];
      end
      if (hit(memReq, `OFS_ADC_CFG_LOW)) begin
        adcCfgLow <= memReq.wdata[3:0];
      end
      if (hit(memReq, `OFS_ADC_CFG_HIGH)) begin
        adcCfgHigh <= memReq.wdata[6:0];
      end
      if (hit(memReq, `OFS_OOK_RATES)) begin
        ookRates <= memReq.wdata[5:0];
      end
      if (hit(memReq, `OFS_LOOP_CFG)) begin
        loopCfg <= memReq.wdata;
      end
      if (hit(memReq, `OFS_LOOP_MODE)) begin
        loopMode <= memReq.wdata[6:0];
      end
    end
  end

  assign modeWrite = memReq.write && hit(memReq, `OFS_LOOP_MODE);

  // Fine RC oscillator result captured from the calibration engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rcOscResult <= 16'h0000;
    end else if (rcOscCalValid) begin
      rcOscResult <= rcOscCalWord;
    end
  end

  bb_osc_cal_seq calSeq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .calEnable(bbFilterCalEnable),
    .measValid(bbOscMeasValid),
    .measWord(bbOscMeasWord),
    .overrideReg(bbOscOverride),
    .calRun(bbFilterCalRun),
    .calDone(bbFilterCalDone),
    .calWord(bbOscCalWord),
    .activeWord(bbOscActiveWord)
  );

  // Analog control fields go straight to the ADC
  assign auxAdcRefSelect = adcCfgLow[1:0];
  assign auxAdcChannelSelect = adcCfgLow[3:2];
  assign auxAdcRefPower = adcCfgHigh[`BIT_REF_POWER];
  assign filtMode = filt_mode_t'(adcCfgHigh[6:5]);

  // Update tick: OOK divides the Manchester symbol rate
  assign rateExp = ookTracking ? ookRates[5:3] : ookRates[2:0];
  assign rateLimit = expLimit(rateExp);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rateCount <= 8'h00;
    end else if (!ookMode) begin
      rateCount <= 8'h00;
    end else if (manchesterTick) begin
      if (rateCount >= rateLimit) begin
        rateCount <= 8'h00;
      end else begin
        rateCount <= rateCount + 8'h01;
      end
    end
  end

  assign loopTick = ookMode ?
    (manchesterTick && rateCount >= rateLimit) : fskLoopTick;

  // First-order smoothing of the ADC samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filtAcc <= 8'h00;
    end else if (adcSampleValid) begin
      filtAcc <= filtAcc + 8'(($signed({2'b00, adcSample}) -
        $signed({2'b00, filtAcc})) >>> `FILTER_SHIFT);
    end
  end

  // Sample fed to the gain loop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loopSample <= 8'h00;
    end else if (filtMode == FILT_ALL) begin
      loopSample <= filtAcc;
    end else if (adcSampleValid) begin
      loopSample <= adcSample;
    end
  end

  // Readback value and its refresh event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adcReadback <= 8'h00;
    end else begin
      case (filtMode)
        FILT_NONE: if (adcSampleValid) adcReadback <= adcSample;
        FILT_ON_READ: if (memReq.read) adcReadback <= filtAcc;
        FILT_ON_TICK: if (loopTick) adcReadback <= filtAcc;
        FILT_ALL: if (loopTick) adcReadback <= filtAcc;
        default: adcReadback <= adcReadback;
      endcase
    end
  end

  // Gain loop operation
  assign loopOp = loop_op_t'(loopMode[6:5]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lockState <= LOCK_TRACK;
    end else if (modeWrite || loopOp != LOOP_LOCK) begin
      lockState <= LOCK_TRACK;
    end else begin
      case (lockState)
        LOCK_TRACK: if (preambleFound) lockState <= LOCK_FROZEN;
        LOCK_FROZEN: lockState <= LOCK_FROZEN;
        default: lockState <= LOCK_TRACK;
      endcase
    end
  end

  // Manual fields; a reserved code keeps the previous setting
  always_comb begin
    manualGain = gain;
    manualGain.extraLow = 1'b0;
    if (loopMode[4:3] != `GAIN_RESERVED) begin
      manualGain.front = loopMode[4:3];
    end
    manualGain.mixer = loopMode[2];
    if (loopMode[1:0] != `GAIN_RESERVED) begin
      manualGain.filter = loopMode[1:0];
    end
  end

  always_comb begin
    next_gain = gain;
    case (loopOp)
      LOOP_FREE: begin
        if (loopTick && gainRaise && !gainLower) begin
          next_gain = stepGain(gain, 1'b1, loopCfg);
        end else if (loopTick && gainLower) begin
          next_gain = stepGain(gain, 1'b0, loopCfg);
        end
      end
      LOOP_MANUAL: next_gain = manualGain;
      LOOP_HOLD: next_gain = gain;
      LOOP_LOCK: begin
        if (lockState == LOCK_TRACK && !preambleFound && loopTick) begin
          if (gainRaise && !gainLower) begin
            next_gain = stepGain(gain, 1'b1, loopCfg);
          end else if (gainLower) begin
            next_gain = stepGain(gain, 1'b0, loopCfg);
          end
        end
      end
      default: next_gain = gain;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain <= '0;
    end else begin
      gain <= next_gain;
    end
  end

  // Registered read data; unmapped addresses and reserved bits read 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memRdata <= 8'h00;
    end else if (memReq.read) begin
      case (memReq.addr)
        `OFS_BB_OSC_READBACK: memRdata <= {2'b00, bbOscCalWord};
        `OFS_BB_OSC_OVERRIDE: memRdata <= {1'b0, bbOscOverride};
        `OFS_RC_OSC_HIGH: memRdata <= rcOscResult[15:8];
        `OFS_RC_OSC_LOW: memRdata <= rcOscResult[7:0];
        `OFS_ADC_CFG_LOW: memRdata <= {4'h0, adcCfgLow};
        `OFS_ADC_CFG_HIGH: memRdata <= {1'b0, adcCfgHigh};
        `OFS_OOK_RATES: memRdata <= {2'b00, ookRates};
        `OFS_LOOP_CFG: memRdata <= loopCfg;
        `OFS_LOOP_MODE: memRdata <= {1'b0, loopMode};
        default: memRdata <= 8'h00;
      endcase
    end
  end

endmodule : agc_adc_cal_ctrl

// [tb/agc_adc_cal_ctrl_sva.sv]
// Checker of the gain-loop register bank, bound to its ports.
// Assumes one clock domain and the offsets header on the include path.
`include "agc_adc_cal_regs.svh"
module agc_adc_cal_ctrl_sva
  import agc_adc_cal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mem_req_t memReq,
  input wire logic [7:0] memRdata,
  input wire logic bbFilterCalEnable,
  input wire logic bbFilterCalDone,
  input wire logic bbFilterCalRun,
  input wire logic bbOscMeasValid,
  input wire logic [5:0] bbOscActiveWord,
  input wire logic [1:0] auxAdcRefSelect,
  input wire logic auxAdcRefPower,
  input wire logic ookMode,
  input wire logic manchesterTick,
  input wire logic loopTick,
  input wire gain_t gain
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic wrMode;
  logic wrOvr;
  logic [1:0] opMode;
  assign wrMode = memReq.write && memReq.addr == `OFS_LOOP_MODE;
  assign wrOvr = memReq.write && memReq.addr == `OFS_BB_OSC_OVERRIDE;
  // Operation mode as last written, to know when hold applies
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      opMode <= 2'h0;
    else if (wrMode)
      opMode <= memReq.wdata[6:5];
  end
  a_word_read_pad: assert property (memReq.read && memReq.addr ==
    `OFS_BB_OSC_READBACK |=> memRdata[7:6] == 2'h0)
    else $error("calibration word readback has upper bits set");
  a_override_word_used: assert property (wrOvr && memReq.wdata[0]
    |=> bbOscActiveWord == $past(memReq.wdata[6:1]))
    else $error("override word not applied");
  a_ref_select_follows: assert property (memReq.write &&
    memReq.addr == `OFS_ADC_CFG_LOW
    |=> auxAdcRefSelect == $past(memReq.wdata[1:0]))
    else $error("reference select does not follow write");
  a_ref_power_follows: assert property (memReq.write &&
    memReq.addr == `OFS_ADC_CFG_HIGH
    |=> auxAdcRefPower == $past(memReq.wdata[4]))
    else $error("reference power does not follow write");
  a_cal_done_sets: assert property (bbFilterCalRun && bbOscMeasValid
    && bbFilterCalEnable |=> bbFilterCalDone)
    else $error("calibration done not raised after measurement");
  a_cal_done_clears: assert property (!bbFilterCalEnable
    |=> !bbFilterCalDone)
    else $error("calibration done high while disabled");
  a_manual_gain_set: assert property (wrMode &&
    memReq.wdata[6:5] == 2'h1 && memReq.wdata[4:3] != 2'h3 &&
    memReq.wdata[1:0] != 2'h3 |-> ##2 {gain.front, gain.mixer,
    gain.filter} == $past(memReq.wdata[4:0], 2))
    else $error("manual gain fields not applied");
  a_hold_freezes: assert property (opMode == 2'h2 && !wrMode
    |=> $stable(gain))
    else $error("gain moved in hold mode");
  a_ook_tick_source: assert property (ookMode && loopTick
    |-> manchesterTick)
    else $error("on-off keying update without symbol tick");
endmodule : agc_adc_cal_ctrl_sva

bind agc_adc_cal_ctrl agc_adc_cal_ctrl_sva i_agc_adc_cal_ctrl_sva (
  .clk_sys, .rst_n, .memReq, .memRdata, .bbFilterCalEnable,
  .bbFilterCalDone, .bbFilterCalRun, .bbOscMeasValid, .bbOscActiveWord,
  .auxAdcRefSelect, .auxAdcRefPower, .ookMode, .manchesterTick,
  .loopTick, .gain
);

// [tb/agc_adc_cal_ctrl_bench.sv]
// Self-checking bench of the gain-loop register bank.
// Assumes a 40 MHz clk_sys and the checker bound beside the design.
module agc_adc_cal_ctrl_bench
  import agc_adc_cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, calEn, calDone, calRun, measValid, rcValid;
  logic adcValid, refPower, ookMode, ookTracking, manTick, fskTick;
  logic loopTick, gainRaise, gainLower, preamble;
  logic [5:0] measWord, activeWord;
  logic [15:0] rcWord;
  logic [7:0] memRdata, adcSample, loopSample, adcReadback;
  logic [1:0] refSel, chSel;
  mem_req_t memReq;
  gain_t gain, held;
  int num_errors, checks, n;
  logic [9:0] tAddr [9] = '{10'h346, 10'h359, 10'h35A, 10'h35B, 10'h35C,
    10'h35D, 10'h345, 10'h34F, 10'h300};
  logic [7:0] tDat [9] = '{8'h7F, 8'hFF, 8'hEF, 8'hFF, 8'h5A, 8'hFF,
    8'hFF, 8'hFF, 8'hFF};
  logic [7:0] tExp [9] = '{8'h7F, 8'h0F, 8'h6F, 8'h3F, 8'h5A, 8'h7F,
    8'h00, 8'h00, 8'h00};
  logic [9:0] rAddr [9] = '{10'h345, 10'h346, 10'h34F, 10'h350, 10'h359,
    10'h35A, 10'h35B, 10'h35C, 10'h35D};
  logic [7:0] rExp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F,
    8'h11, 8'h9C, 8'h00};

  agc_adc_cal_ctrl i_agc_adc_cal_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .memReq(memReq), .memRdata(memRdata), .bbFilterCalEnable(calEn),
    .bbFilterCalDone(calDone), .bbFilterCalRun(calRun),
    .bbOscMeasValid(measValid), .bbOscMeasWord(measWord),
    .bbOscActiveWord(activeWord), .rcOscCalValid(rcValid),
    .rcOscCalWord(rcWord), .auxAdcRefSelect(refSel),
    .auxAdcChannelSelect(chSel), .auxAdcRefPower(refPower),
    .adcSampleValid(adcValid), .adcSample(adcSample),
    .loopSample(loopSample), .adcReadback(adcReadback),
    .ookMode(ookMode), .ookTracking(ookTracking),
    .manchesterTick(manTick), .fskLoopTick(fskTick), .loopTick(loopTick),
    .gainRaise(gainRaise), .gainLower(gainLower), .preambleFound(preamble),
    .gain(gain));

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    memReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    memReq.write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    memReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    memReq.read <= 1'b0;
    #1;
  endtask : rd
  // Gain loop tick from the frequency-keyed source
  task automatic fskPulse();
    @(posedge clk_sys);
    fskTick <= 1'b1;
    @(posedge clk_sys);
    fskTick <= 1'b0;
  endtask : fskPulse
  // Counts gain-loop updates over a run of symbol ticks
  task automatic ookCount(input int pulses);
    n = 0;
    for (int k = 0; k < pulses; k++) begin
      @(posedge clk_sys);
      manTick <= 1'b1;
      #1;
      if (loopTick === 1'b1) n++;
      @(posedge clk_sys);
      manTick <= 1'b0;
    end
  endtask : ookCount
  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  initial begin
    {rst_n, calEn, measValid, rcValid, adcValid} = '0;
    {ookMode, ookTracking, manTick, fskTick, gainRaise} = '0;
    {gainLower, preamble} = '0;
    {measWord, rcWord, adcSample, memReq} = '0;
    num_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(tAddr[i], tDat[i]);
      rd(tAddr[i]);
      chk(memRdata, tExp[i]);
    end
    @(posedge clk_sys);
    rst_n <= 1'b0;
    step(2);
    chk(refPower, 1'b1);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(rAddr[i]);
      chk(memRdata, rExp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(10'h359, 8'(i * 5));
      chk(refSel, 16'(i));
      chk(chSel, 16'(i));
    end
    wr(10'h35A, 8'h0F);
    chk(refPower, 1'b0);
    wr(10'h35A, 8'h1F);
    @(posedge clk_sys);
    calEn <= 1'b1;
    for (int k = 0; k < 20 && calRun !== 1'b1; k++) step(1);
    chk(calRun, 1'b1);
    @(posedge clk_sys);
    measValid <= 1'b1;
    measWord <= 6'h2A;
    @(posedge clk_sys);
    measValid <= 1'b0;
    measWord <= 6'h15;
    #1;
    chk(calDone, 1'b1);
    @(posedge clk_sys);
    measValid <= 1'b1;
    @(posedge clk_sys);
    measValid <= 1'b0;
    rd(10'h345);
    chk(memRdata, 8'h2A);
    chk(activeWord, 6'h2A);
    wr(10'h346, 8'h2B);
    chk(activeWord, 6'h15);
    wr(10'h346, 8'h00);
    @(posedge clk_sys);
    calEn <= 1'b0;
    step(2);
    chk(calDone, 1'b0);
    @(posedge clk_sys);
    rcValid <= 1'b1;
    rcWord <= 16'hA55A;
    @(posedge clk_sys);
    rcValid <= 1'b0;
    rd(10'h34F);
    chk(memRdata, 8'hA5);
    rd(10'h350);
    chk(memRdata, 8'h5A);
    @(posedge clk_sys);
    adcValid <= 1'b1;
    adcSample <= 8'h40;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    step(2);
    chk(adcReadback, 8'h40);
    chk(loopSample, 8'h40);
    wr(10'h35A, 8'h7F);
    @(posedge clk_sys);
    adcValid <= 1'b1;
    adcSample <= 8'h80;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    step(2);
    chk(loopSample, 8'h2C);
    wr(10'h35A, 8'h3F);
    chk(adcReadback, 8'h40);
    rd(10'h359);
    chk(adcReadback, 8'h2C);
    wr(10'h35A, 8'h5F);
    @(posedge clk_sys);
    adcValid <= 1'b1;
    adcSample <= 8'hC0;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    step(2);
    chk(adcReadback, 8'h2C);
    chk(loopSample, 8'hC0);
    fskPulse();
    step(1);
    chk(adcReadback, 8'h51);
    wr(10'h35D, 8'h35);
    step(1);
    chk({gain.front, gain.mixer, gain.filter}, 5'h15);
    wr(10'h35D, 8'h38);
    step(1);
    chk({gain.front, gain.mixer, gain.filter}, 5'h10);
    wr(10'h35D, 8'h40);
    step(1);
    held = gain;
    @(posedge clk_sys);
    gainRaise <= 1'b1;
    repeat (3) fskPulse();
    step(2);
    chk(gain, held);
    wr(10'h35D, 8'h00);
    fskPulse();
    step(2);
    chk({gain.front, gain.mixer, gain.filter}, 5'h14);
    @(posedge clk_sys);
    gainRaise <= 1'b0;
    gainLower <= 1'b1;
    wr(10'h35D, 8'h60);
    fskPulse();
    step(2);
    chk({gain.front, gain.mixer, gain.filter}, 5'h10);
    @(posedge clk_sys);
    preamble <= 1'b1;
    @(posedge clk_sys);
    preamble <= 1'b0;
    fskPulse();
    step(2);
    chk({gain.front, gain.mixer, gain.filter}, 5'h10);
    wr(10'h35D, 8'h60);
    fskPulse();
    step(2);
    chk({gain.front, gain.mixer, gain.filter}, 5'h08);
    wr(10'h35C, 8'h9D);
    wr(10'h35D, 8'h35);
    wr(10'h35D, 8'h00);
    @(posedge clk_sys);
    gainLower <= 1'b0;
    gainRaise <= 1'b1;
    fskPulse();
    step(2);
    chk({gain.front, gain.mixer, gain.filter}, 5'h15);
    wr(10'h35C, 8'h9E);
    wr(10'h35D, 8'h20);
    wr(10'h35D, 8'h00);
    @(posedge clk_sys);
    gainRaise <= 1'b0;
    gainLower <= 1'b1;
    fskPulse();
    step(2);
    chk(gain, 6'h20);
    @(posedge clk_sys);
    gainLower <= 1'b0;
    wr(10'h35B, 8'h11);
    @(posedge clk_sys);
    ookMode <= 1'b1;
    ookCount(8);
    chk(n, 2);
    ookTracking <= 1'b1;
    ookCount(16);
    chk(n, 2);
    ookMode <= 1'b0;
    step(2);
    close_out();
  end
endmodule : agc_adc_cal_ctrl_bench
